// File: tmc_pkg.sv
// Shared constants for the trace macrocell signal interface.
package tmc_pkg;
    localparam int ADDR_W = 32;
    localparam int PKT_W = 16;
    localparam int BUF_W = PKT_W + 1;
    localparam int BUF_DEPTH = 2;
    localparam int LVL_W = 2;
    localparam int THR_W = 3;
    localparam int BYTES_PER_WORD = 2;
    localparam logic [31:0] STEP_COMPRESSED = 32'h0000_0002;
    localparam logic [31:0] STEP_NORMAL = 32'h0000_0004;
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
    localparam logic [15:0] RST_PKT = 16'h0000;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [2:0] RST_WIDTH = 3'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_TRIG = 4'h0;
    localparam logic [2:0] DATA_TAG = 3'h5;

    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_BR_HI = 2'b01,
        SEQ_CTX_LO = 2'b10,
        SEQ_CTX_HI = 2'b11
    } tmc_seq_t;
endpackage

// File: tmc_pkt_buf.sv
// Two-entry packet buffer with valid and ready on both sides.
`timescale 1ns/1ps
module tmc_pkt_buf
(
    // Clock, reset and stall
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic en,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [tmc_pkg::BUF_W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [tmc_pkg::BUF_W-1:0] out_data,
    // Occupancy
    output logic [tmc_pkg::LVL_W-1:0] level
);
    logic [tmc_pkg::BUF_W-1:0] mem [tmc_pkg::BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic next_wr_ptr;
    logic next_rd_ptr;
    logic [tmc_pkg::LVL_W-1:0] next_level;
    logic do_wr;
    logic do_rd;

    assign in_ready = (level != tmc_pkg::LVL_W'(tmc_pkg::BUF_DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];

    always_comb
    begin
        do_wr = en && in_valid && in_ready;
        do_rd = en && out_valid && out_ready;
        next_wr_ptr = do_wr ? ~wr_ptr : wr_ptr;
        next_rd_ptr = do_rd ? ~rd_ptr : rd_ptr;
        next_level = level + tmc_pkg::LVL_W'(do_wr) - tmc_pkg::LVL_W'(do_rd);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            level <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level <= next_level;
        end
    end

    // Storage needs no reset; valid words are tracked by level.
    always_ff @(posedge clk_sys)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // tmc_pkt_buf

// File: tmc_decode_pipe.sv
// Pipelined copies of core bus signals for the memory-map-decode block.
`timescale 1ns/1ps
module tmc_decode_pipe
(
    // Clock, reset and stall
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic en,
    // Core side
    input wire logic [31:0] core_address,
    input wire logic [1:0] access_size,
    input wire logic memory_request_n,
    input wire logic opcode_fetch_n,
    input wire logic access_direction,
    input wire logic compressed_isa_state,
    // Decode side
    output logic [31:0] decode_address_copy,
    output logic [1:0] decode_size_copy,
    output logic decode_request_copy,
    output logic decode_fetch_copy,
    output logic decode_direction_copy,
    output logic decode_isa_state_copy
);
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            decode_address_copy <= tmc_pkg::RST_ADDR;
            decode_size_copy <= tmc_pkg::RST_MODE;
            decode_request_copy <= 1'b1;
            decode_fetch_copy <= 1'b1;
            decode_direction_copy <= 1'b0;
            decode_isa_state_copy <= 1'b0;
        end
        else if (en)
        begin
            decode_address_copy <= core_address;
            decode_size_copy <= access_size;
            decode_request_copy <= memory_request_n;
            decode_fetch_copy <= opcode_fetch_n;
            decode_direction_copy <= access_direction;
            decode_isa_state_copy <= compressed_isa_state;
        end
    end
endmodule // tmc_decode_pipe

// File: tmc_trace_if.sv
// Trace macrocell signal interface: core watcher, packet emitter and status outputs.
`timescale 1ns/1ps
module tmc_trace_if
(
    // Clock and resets
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clock_stall_enable,
    input wire logic macrocell_reset_n,
    input wire logic test_reset_n,
    // Core bus and pipeline status
    input wire logic [31:0] core_address,
    input wire logic memory_request_n,
    input wire logic opcode_fetch_n,
    input wire logic access_direction,
    input wire logic [1:0] access_size,
    input wire logic consecutive_access,
    input wire logic compressed_isa_state,
    input wire logic byte_order_select,
    input wire logic execute_stage_valid,
    input wire logic instruction_executed_n,
    input wire logic [31:0] context_identifier,
    input wire logic context_write_strobe,
    input wire logic watchpoint_match_zero,
    input wire logic watchpoint_match_one,
    input wire logic [7:0] system_option_straps,
    // Configuration from the debugger
    input wire logic trace_enable_ctrl,
    input wire logic half_rate_mode,
    input wire logic [1:0] port_mode_cfg,
    input wire logic [2:0] port_width_cfg,
    input wire logic fifo_warn_enable,
    input wire logic [2:0] fifo_threshold,
    input wire logic address_on_off_trace_control,
    input wire logic [31:0] trace_start_address,
    input wire logic [31:0] trace_stop_address,
    input wire logic [7:0] decode_control_cfg,
    input wire logic debug_request_enable,
    // Trace port
    input wire logic trace_port_ready,
    output logic trace_packet_valid,
    output logic [15:0] trace_packet_bus,
    output logic trace_branch_sync,
    output logic [1:0] trace_port_mode,
    output logic [2:0] trace_port_width,
    // Status
    output logic half_rate_indicator,
    output logic trace_enabled_status,
    output logic fifo_level_warning,
    output logic power_down_allowed,
    output logic [7:0] system_option_readback,
    output logic debug_request,
    output logic [3:0] external_trigger_out,
    // Memory-map-decode interface
    output logic [31:0] decode_address_copy,
    output logic [1:0] decode_size_copy,
    output logic decode_request_copy,
    output logic decode_fetch_copy,
    output logic decode_direction_copy,
    output logic decode_isa_state_copy,
    output logic [7:0] decode_control_bus,
    input wire logic [15:0] decode_result_inputs
);
    // ----------------------------------------
    // Reset pin synchronisers
    // ----------------------------------------
    logic mrst_s1;
    logic mrst_s2;
    logic trst_s1;
    logic trst_s2;
    logic hold;
    logic en;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mrst_s1 <= 1'b0;
            mrst_s2 <= 1'b0;
            trst_s1 <= 1'b0;
            trst_s2 <= 1'b0;
        end
        else
        begin
            mrst_s1 <= macrocell_reset_n;
            mrst_s2 <= mrst_s1;
            trst_s1 <= test_reset_n;
            trst_s2 <= trst_s1;
        end
    end

    assign hold = !mrst_s2;
    assign en = clock_stall_enable;

    // ----------------------------------------
    // Packet sequencer and core tracking
    // ----------------------------------------
    tmc_pkg::tmc_seq_t seq_state;
    tmc_pkg::tmc_seq_t next_seq_state;
    logic [31:0] last_pc;
    logic [31:0] next_last_pc;
    logic trace_on;
    logic next_trace_on;
    logic pend_br;
    logic next_pend_br;
    logic [31:0] br_addr;
    logic [31:0] next_br_addr;
    logic pend_ctx;
    logic next_pend_ctx;
    logic [31:0] ctx_word;
    logic [31:0] next_ctx_word;
    logic pend_data;
    logic next_pend_data;
    logic [15:0] data_word;
    logic [15:0] next_data_word;
    logic req_q;
    logic dir_q;
    logic [1:0] size_q;
    logic seq_q;
    logic fetch_q;
    logic executed;
    logic [31:0] step;
    logic branch;
    logic push;
    logic [tmc_pkg::BUF_W-1:0] push_word;
    logic buf_ready;
    logic buf_valid;
    logic [tmc_pkg::BUF_W-1:0] buf_data;
    logic [tmc_pkg::LVL_W-1:0] buf_level;
    logic [31:0] ctx_ordered;

    assign executed = execute_stage_valid && !instruction_executed_n;
    assign step = compressed_isa_state ? tmc_pkg::STEP_COMPRESSED : tmc_pkg::STEP_NORMAL;
    assign branch = executed && (core_address != last_pc + step);
    // byte order sets context byte lanes
    assign ctx_ordered = byte_order_select ? {context_identifier[7:0], context_identifier[15:8],
        context_identifier[23:16], context_identifier[31:24]} : context_identifier;

    always_comb
    begin
        next_seq_state = seq_state;
        next_last_pc = executed ? core_address : last_pc;
        next_trace_on = trace_on;
        next_pend_br = pend_br;
        next_br_addr = br_addr;
        next_pend_ctx = pend_ctx;
        next_ctx_word = ctx_word;
        next_pend_data = pend_data;
        next_data_word = data_word;
        push = 1'b0;
        push_word = '0;
        // start and stop addresses gate tracing
        if (!address_on_off_trace_control)
        begin
            next_trace_on = trace_enabled_status;
        end
        else if (!trace_enabled_status || (executed && core_address == trace_stop_address))
        begin
            next_trace_on = 1'b0;
        end
        else if (executed && core_address == trace_start_address)
        begin
            next_trace_on = 1'b1;
        end
        unique case (seq_state)
            tmc_pkg::SEQ_IDLE:
            begin
                if (pend_br)
                begin
                    push = 1'b1;
                    push_word = {1'b1, br_addr[15:1], compressed_isa_state};
                    if (buf_ready)
                    begin
                        next_pend_br = 1'b0;
                        next_seq_state = tmc_pkg::SEQ_BR_HI;
                    end
                end
                else if (pend_data)
                begin
                    push = 1'b1;
                    push_word = {1'b0, data_word};
                    if (buf_ready)
                    begin
                        next_pend_data = 1'b0;
                    end
                end
                else if (pend_ctx && buf_ready)
                begin
                    next_seq_state = tmc_pkg::SEQ_CTX_LO;
                end
            end
            tmc_pkg::SEQ_BR_HI:
            begin
                push = 1'b1;
                push_word = {1'b0, br_addr[31:16]};
                if (buf_ready)
                begin
                    next_seq_state = tmc_pkg::SEQ_IDLE;
                end
            end
            tmc_pkg::SEQ_CTX_LO:
            begin
                push = 1'b1;
                push_word = {1'b0, ctx_word[15:0]};
                if (buf_ready)
                begin
                    next_seq_state = tmc_pkg::SEQ_CTX_HI;
                end
            end
            tmc_pkg::SEQ_CTX_HI:
            begin
                push = 1'b1;
                push_word = {1'b0, ctx_word[31:16]};
                if (buf_ready)
                begin
                    next_pend_ctx = 1'b0;
                    next_seq_state = tmc_pkg::SEQ_IDLE;
                end
            end
        endcase
        // A new branch replaces a pending one; the newest target is what matters.
        if (trace_on && branch && seq_state != tmc_pkg::SEQ_BR_HI)
        begin
            next_pend_br = 1'b1;
            next_br_addr = core_address;
        end
        // access announced last cycle happens now
        // direction and size ride in the data word
        // consecutive accesses give no data word
        if (trace_on && req_q && fetch_q && !seq_q)
        begin
            next_pend_data = 1'b1;
            next_data_word = {tmc_pkg::DATA_TAG, dir_q, size_q, core_address[9:0]};
        end
        if (context_write_strobe)
        begin
            next_pend_ctx = 1'b1;
            next_ctx_word = ctx_ordered;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || hold)
        begin
            seq_state <= tmc_pkg::SEQ_IDLE;
            last_pc <= tmc_pkg::RST_ADDR;
            trace_on <= 1'b0;
            pend_br <= 1'b0;
            br_addr <= tmc_pkg::RST_ADDR;
            pend_ctx <= 1'b0;
            ctx_word <= tmc_pkg::RST_ADDR;
            pend_data <= 1'b0;
            data_word <= tmc_pkg::RST_PKT;
            req_q <= 1'b0;
            dir_q <= 1'b0;
            size_q <= tmc_pkg::RST_MODE;
            seq_q <= 1'b0;
            fetch_q <= 1'b1;
        end
        else if (en)
        begin
            seq_state <= next_seq_state;
            last_pc <= next_last_pc;
            trace_on <= next_trace_on;
            pend_br <= next_pend_br;
            br_addr <= next_br_addr;
            pend_ctx <= next_pend_ctx;
            ctx_word <= next_ctx_word;
            pend_data <= next_pend_data;
            data_word <= next_data_word;
            req_q <= !memory_request_n;
            dir_q <= access_direction;
            size_q <= access_size;
            seq_q <= consecutive_access;
            fetch_q <= opcode_fetch_n;
        end
    end

    // ----------------------------------------
    // Packet buffer and trace port
    // ----------------------------------------
    // The buffer lets a receiver stall without losing a word; the sequencer waits on it.
    tmc_pkt_buf u_buf
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n && !hold),
        .en(en),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(push_word),
        .out_valid(buf_valid),
        .out_ready(trace_port_ready),
        .out_data(buf_data),
        .level(buf_level)
    );

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    logic fifo_low;

    assign fifo_low = ({1'b0, buf_level} * 3'(tmc_pkg::BYTES_PER_WORD)) < fifo_threshold;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || hold)
        begin
            trace_packet_valid <= 1'b0;
            trace_packet_bus <= tmc_pkg::RST_PKT;
            trace_branch_sync <= 1'b0;
            trace_port_mode <= tmc_pkg::RST_MODE;
            trace_port_width <= tmc_pkg::RST_WIDTH;
            half_rate_indicator <= 1'b0;
            trace_enabled_status <= 1'b0;
            fifo_level_warning <= 1'b0;
            power_down_allowed <= 1'b0;
            system_option_readback <= tmc_pkg::RST_BYTE;
            debug_request <= 1'b0;
            external_trigger_out <= tmc_pkg::RST_TRIG;
            decode_control_bus <= tmc_pkg::RST_BYTE;
        end
        else if (en)
        begin
            trace_packet_valid <= buf_valid && trace_port_ready;
            trace_packet_bus <= buf_data[15:0];
            trace_branch_sync <= buf_valid && trace_port_ready && buf_data[16];
            trace_port_mode <= port_mode_cfg;
            trace_port_width <= port_width_cfg;
            half_rate_indicator <= half_rate_mode;
            // enable follows debugger and test reset
            trace_enabled_status <= trace_enable_ctrl && trst_s2;
            fifo_level_warning <= fifo_warn_enable && fifo_low;
            // idle only with tracing off, buffer empty and sequencer in SEQ_IDLE
            power_down_allowed <= !trace_enabled_status && !buf_valid && seq_state == tmc_pkg::SEQ_IDLE;
            system_option_readback <= system_option_straps;
            debug_request <= debug_request_enable && watchpoint_match_one;
            external_trigger_out <= {|decode_result_inputs[15:8], |decode_result_inputs[7:0],
                watchpoint_match_one, watchpoint_match_zero};
            decode_control_bus <= decode_control_cfg;
        end
    end

    tmc_decode_pipe u_pipe
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .en(en),
        .core_address(core_address),
        .access_size(access_size),
        .memory_request_n(memory_request_n),
        .opcode_fetch_n(opcode_fetch_n),
        .access_direction(access_direction),
        .compressed_isa_state(compressed_isa_state),
        .decode_address_copy(decode_address_copy),
        .decode_size_copy(decode_size_copy),
        .decode_request_copy(decode_request_copy),
        .decode_fetch_copy(decode_fetch_copy),
        .decode_direction_copy(decode_direction_copy),
        .decode_isa_state_copy(decode_isa_state_copy)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_stall_freeze: assert property (!en && !hold ##1 !hold |-> $stable(seq_state) && $stable(last_pc))
        else $error("state moved during stall");
    chk_half_rate: assert property (en && !hold |=> half_rate_indicator == $past(half_rate_mode))
        else $error("half-rate indicator wrong");
    chk_enabled_status: assert property (en && !hold
        |=> trace_enabled_status == $past(trace_enable_ctrl && trst_s2))
        else $error("enabled status wrong");
    chk_fifo_warn: assert property (en && !hold |=> fifo_level_warning == $past(fifo_warn_enable && fifo_low))
        else $error("fifo warning wrong");
    chk_decode_addr: assert property (en |=> decode_address_copy == $past(core_address))
        else $error("decode address copy stale");
    chk_sync_start: assert property (en && !hold && seq_state == tmc_pkg::SEQ_IDLE && pend_br && buf_ready
        |=> seq_state == tmc_pkg::SEQ_BR_HI)
        else $error("branch sequence did not start");
    chk_ctx_queue: assert property (en && !hold && context_write_strobe |=> pend_ctx)
        else $error("context write lost");
    chk_reset_quiet: assert property (hold
        |=> !debug_request && external_trigger_out == 4'h0 && !trace_packet_valid)
        else $error("outputs active in reset");
    chk_stop_addr: assert property (en && !hold && address_on_off_trace_control && executed
        && core_address == trace_stop_address |=> !trace_on)
        else $error("tracing not stopped");
endmodule // tmc_trace_if

// File: tmc_core_model.sv
// Core-side model that executes instructions and updates the context identifier.
`timescale 1ns/1ps
module tmc_core_model
(
    // Clock and commands
    input wire logic clk_sys,
    input wire logic exec_go,
    input wire logic [31:0] exec_addr,
    input wire logic ctx_go,
    input wire logic [31:0] ctx_val,
    // Core outputs
    output logic [31:0] core_address,
    output logic execute_stage_valid,
    output logic instruction_executed_n,
    output logic [31:0] context_identifier,
    output logic context_write_strobe
);
    initial
    begin
        core_address = 32'h0000_0000;
        execute_stage_valid = 1'b0;
        instruction_executed_n = 1'b1;
        context_identifier = 32'h0000_0000;
        context_write_strobe = 1'b0;
    end
    always @(posedge clk_sys)
    begin
        instruction_executed_n <= !exec_go;
        execute_stage_valid <= exec_go;
        if (exec_go)
            core_address <= exec_addr;
        context_write_strobe <= ctx_go;
        if (ctx_go)
            context_identifier <= ctx_val;
    end
endmodule // tmc_core_model

// File: trace_macrocell_signal_interface_test.sv
// Self-checking testbench for the trace macrocell signal interface.
`timescale 1ns/1ps
module trace_macrocell_signal_interface_test;
    logic clk_sys = 1'b0, rst_n = 1'b0, clock_stall_enable = 1'b1, macrocell_reset_n = 1'b1;
    logic test_reset_n = 1'b1, byte_order_select = 1'b0, memory_request_n = 1'b1, opcode_fetch_n = 1'b1;
    logic access_direction = 1'b0, consecutive_access = 1'b0, compressed_isa_state = 1'b0;
    logic watchpoint_match_zero = 1'b0, watchpoint_match_one = 1'b0, trace_enable_ctrl = 1'b0;
    logic half_rate_mode = 1'b0, fifo_warn_enable = 1'b0, address_on_off_trace_control = 1'b0;
    logic debug_request_enable = 1'b0, trace_port_ready = 1'b1, exec_go = 1'b0, ctx_go = 1'b0;
    logic [1:0] access_size = 2'h0, port_mode_cfg = 2'h0;
    logic [2:0] port_width_cfg = 3'h0, fifo_threshold = 3'h0;
    logic [7:0] system_option_straps = 8'h5A, decode_control_cfg = 8'h00;
    logic [15:0] decode_result_inputs = 16'h0000;
    logic [31:0] trace_start_address = 32'h0000_0000, trace_stop_address = 32'h0000_0000;
    logic [31:0] exec_addr = 32'h0000_0000, ctx_val = 32'h0000_0000;
    logic [31:0] core_address, context_identifier, decode_address_copy;
    logic execute_stage_valid, instruction_executed_n, context_write_strobe, trace_packet_valid;
    logic trace_branch_sync, half_rate_indicator, trace_enabled_status, fifo_level_warning;
    logic power_down_allowed, debug_request, decode_request_copy, decode_fetch_copy;
    logic decode_direction_copy, decode_isa_state_copy;
    logic [15:0] trace_packet_bus, w;
    logic [1:0] trace_port_mode, decode_size_copy;
    logic [2:0] trace_port_width;
    logic [7:0] system_option_readback, decode_control_bus;
    logic [3:0] external_trigger_out;
    logic s;
    int err_total = 0, n_compared = 0;
    tmc_trace_if DUT (.*);
    tmc_core_model core (.*);
    always #2 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic run_at(input logic [31:0] a);
        exec_addr = a;
        exec_go = 1'b1;
        tick(1);
        exec_go = 1'b0;
    endtask
    // Packet words stand one cycle, so the wait samples every cycle.
    task automatic get_word(output logic [15:0] wd, output logic sy);
        int k;
        k = 0;
        while (trace_packet_valid !== 1'b1 && k < 60)
        begin
            tick(1);
            k++;
        end
        chk("packet valid", trace_packet_valid, 32'h0000_0001);
        wd = trace_packet_bus;
        sy = trace_branch_sync;
        tick(1);
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // A hang past 5000 cycles, well beyond the expected run of about a hundred, ends the run.
    initial
    begin
        #20000;
        err_total++;
        print_verdict();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        tick(6);
        chk("request copy in reset", decode_request_copy, 32'h0000_0001);
        chk("valid in reset", trace_packet_valid, 32'h0000_0000);
        rst_n = 1'b1;
        tick(3);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            half_rate_mode = i[0];
            port_mode_cfg = i[1:0];
            port_width_cfg = 3'(i + 3);
            decode_control_cfg = 8'(i * 17);
            tick(1);
            chk("half rate", half_rate_indicator, 32'(i % 2));
            chk("port mode", trace_port_mode, 32'(i));
            chk("port width", trace_port_width, 32'(i + 3));
            chk("decode control", decode_control_bus, 32'(i * 17));
        end
        chk("straps", system_option_readback, 32'h0000_005A);
        chk("power down idle", power_down_allowed, 32'h0000_0001);
        clock_stall_enable = 1'b0;
        half_rate_mode = 1'b0;
        tick(3);
        chk("stalled half rate", half_rate_indicator, 32'h0000_0001);
        clock_stall_enable = 1'b1;
        tick(1);
        chk("resumed half rate", half_rate_indicator, 32'h0000_0000);
        $display("test status done");
        memory_request_n = 1'b0;
        access_direction = 1'b1;
        access_size = 2'h2;
        compressed_isa_state = 1'b1;
        opcode_fetch_n = 1'b0;
        tick(1);
        chk("request copy", decode_request_copy, 32'h0000_0000);
        chk("direction copy", decode_direction_copy, 32'h0000_0001);
        chk("size copy", decode_size_copy, 32'h0000_0002);
        chk("isa copy", decode_isa_state_copy, 32'h0000_0001);
        chk("fetch copy", decode_fetch_copy, 32'h0000_0000);
        memory_request_n = 1'b1;
        compressed_isa_state = 1'b0;
        opcode_fetch_n = 1'b1;
        tick(1);
        $display("test decode done");
        trace_enable_ctrl = 1'b1;
        trace_port_ready = 1'b0;
        tick(2);
        chk("enabled status", trace_enabled_status, 32'h0000_0001);
        chk("power down busy", power_down_allowed, 32'h0000_0000);
        run_at(32'h1234_5678);
        tick(12);
        chk("held while stalled", trace_packet_valid, 32'h0000_0000);
        trace_port_ready = 1'b1;
        get_word(w, s);
        chk("branch low", w, 32'h0000_5678);
        chk("branch sync", s, 32'h0000_0001);
        get_word(w, s);
        chk("branch high", w, 32'h0000_1234);
        chk("no sync on high", s, 32'h0000_0000);
        $display("test branch done");
        // context id, low half first, in both byte orders.
        for (int b = 0; b < 2; b++)
        begin
            byte_order_select = b[0];
            ctx_val = 32'hA5C3_0F96;
            ctx_go = 1'b1;
            tick(1);
            ctx_go = 1'b0;
            get_word(w, s);
            chk("context low", w, (b == 0) ? 32'h0000_0F96 : 32'h0000_C3A5);
            get_word(w, s);
            chk("context high", w, (b == 0) ? 32'h0000_A5C3 : 32'h0000_960F);
        end
        $display("test context done");
        // stop and start addresses switch tracing.
        address_on_off_trace_control = 1'b1;
        trace_start_address = 32'h0000_0100;
        trace_stop_address = 32'h0000_0200;
        run_at(32'h0000_0200);
        get_word(w, s);
        chk("stop branch low", w, 32'h0000_0200);
        get_word(w, s);
        chk("stop branch high", w, 32'h0000_0000);
        run_at(32'h0000_0300);
        tick(6);
        chk("off no packet", trace_packet_valid, 32'h0000_0000);
        run_at(32'h0000_0100);
        tick(1);
        run_at(32'h0000_0400);
        get_word(w, s);
        chk("start branch low", w, 32'h0000_0400);
        chk("start branch sync", s, 32'h0000_0001);
        get_word(w, s);
        chk("start branch high", w, 32'h0000_0000);
        $display("test on off done");
        // a traced write access gives one data word.
        memory_request_n = 1'b0;
        access_direction = 1'b1;
        access_size = 2'h2;
        tick(1);
        memory_request_n = 1'b1;
        get_word(w, s);
        chk("data word", w, 32'h0000_B800);
        chk("data no sync", s, 32'h0000_0000);
        $display("test data done");
        fifo_warn_enable = 1'b1;
        fifo_threshold = 3'h7;
        watchpoint_match_zero = 1'b1;
        watchpoint_match_one = 1'b1;
        debug_request_enable = 1'b1;
        decode_result_inputs = 16'h0100;
        tick(2);
        chk("warn below", fifo_level_warning, 32'h0000_0001);
        chk("trigger", external_trigger_out, 32'h0000_000B);
        chk("debug request", debug_request, 32'h0000_0001);
        fifo_threshold = 3'h0;
        tick(2);
        chk("warn zero", fifo_level_warning, 32'h0000_0000);
        macrocell_reset_n = 1'b0;
        tick(4);
        chk("trigger in reset", external_trigger_out, 32'h0000_0000);
        chk("status in reset", trace_enabled_status, 32'h0000_0000);
        chk("debug in reset", debug_request, 32'h0000_0000);
        $display("test warn done");
        print_verdict();
    end
endmodule // trace_macrocell_signal_interface_test
